/* verilog/flash_host_pkg.sv */
// constants and types for the flash erase and status host controller
package flash_host_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS       = 50;
    localparam int T_WE_LOW_NS  = 100;
    localparam int T_ACCESS_NS  = 120;
    localparam int T_GAP_NS     = 50;
    localparam int T_PWD_REC_NS = 700;
    localparam int SYNC_STAGES  = 2;
    // least times round up to whole cycles
    localparam logic [7:0] WE_CYC  = 8'((T_WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RD_CYC  = 8'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
    localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] REC_CYC = 8'((T_PWD_REC_NS + CLK_NS - 1) / CLK_NS);

    // ************************************************************
    // register map of the controller
    // ************************************************************
    localparam logic [3:0] CMD_OFS    = 4'h0;
    localparam logic [3:0] SECTOR_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [3:0] CTRL_OFS   = 4'hC;
    localparam int BUSY_POS    = 8;
    localparam int REFUSED_POS = 9;
    localparam int LOCK_POS    = 10;
    localparam int ERASING_POS = 11;
    localparam int SUSP_POS    = 12;
    localparam int PWD_POS     = 0;

    // command codes written to the command register
    localparam logic [3:0] CMD_CHIP    = 4'h1;
    localparam logic [3:0] CMD_SECTOR  = 4'h2;
    localparam logic [3:0] CMD_SUSPEND = 4'h3;
    localparam logic [3:0] CMD_RESUME  = 4'h4;
    localparam logic [3:0] CMD_RDSTAT  = 4'h5;
    localparam logic [3:0] CMD_CLRSTAT = 4'h6;
    localparam logic [3:0] CMD_RDARRAY = 4'h7;
    localparam logic [3:0] CMD_POLL    = 4'h8;
    localparam logic [3:0] CMD_WAIT    = 4'h9;

    // ************************************************************
    // device status byte
    // ************************************************************
    localparam int READY_POS        = 7;
    localparam int SUSPEND_POS      = 6;
    localparam int ERASE_FAIL_POS   = 5;
    localparam int PROGRAM_FAIL_POS = 4;
    localparam int PROTECT_POS      = 3;
    localparam int SLEEP_POS        = 2;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic [7:0] STATUS_MASK  = 8'hFC;

    // device command bytes
    localparam logic [7:0] SETUP_CODE  = 8'h80;
    localparam logic [7:0] CHIP_CODE   = 8'h10;
    localparam logic [7:0] SECTOR_CODE = 8'h30;
    // codes and unlock addresses below are arbitrary defaults
    localparam logic [19:0] UNLOCK1_ADDR_DEF = 20'h00001;
    localparam logic [19:0] UNLOCK2_ADDR_DEF = 20'h00002;
    localparam logic [7:0]  UNLOCK1_DATA_DEF = 8'h01;
    localparam logic [7:0]  UNLOCK2_DATA_DEF = 8'h02;
    localparam logic [19:0] CMD_ADDR_DEF     = 20'h00000;
    localparam logic [7:0]  SUSPEND_DEF      = 8'h03;
    localparam logic [7:0]  RESUME_DEF       = 8'h04;
    localparam logic [7:0]  RDSTAT_DEF       = 8'h05;
    localparam logic [7:0]  CLRSTAT_DEF      = 8'h06;
    localparam logic [7:0]  RDARRAY_DEF      = 8'h07;

    typedef enum logic [3:0] {
        op_none, op_chip, op_sector, op_suspend, op_resume,
        op_rdstat, op_clrstat, op_rdarray, op_poll
    } op_type;

    typedef enum logic [2:0] {
        st_idle, st_setup, st_strobe, st_hold, st_read, st_gap
    } phase_type;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0]  data;
        logic        last;
        logic        is_read;
    } step_type;

endpackage

/* verilog/flash_erase_status_sequencer.sv */
// host controller issuing erase and status sequences to a parallel flash
`timescale 1ns/1ps
// How it works
// [R1] chip erase: unlock, unlock, 80, unlock, unlock, 10
// [R2] sector erase: same, final 30 at sector
// [R3] device latches address falling, data rising strobe
// [R4] erase starts last write, ends ready bit
// [R5] status reads persist until next valid command
// [R6] address bits 19:16 choose sector
// [R7] suspend only honoured while erase runs
// [R8] suspend sets bit 6, then ready bit
// [R9] suspended: only array, status, abort, resume
// [R10] suspended machine idles; powerdown stops all
// [R11] resume clears bit 6 after suspend only
// [R12] status reads stay until read array
// [R13] status on bits 7:2, low bits zero
// [R14] status latched per strobe; toggle each poll
// [R15] fail bits stay set until clear status
// [R16] status returned after erase or status command
// [R17] after powerup or powerdown status is 1000
// [R18] bit 3 mirrors protection, never changed
// [R19] bit 2 set in sleep, cleared by array
// [R20] fail bit set blocks erase until cleared
// [R21] bits 7:4 encode ready, suspend, erase fail, program fail
// [R22] host selects read source before reading
// [R23] bit meanings: ready, suspended, erase, program fail
// [R24] powerdown low resets the status register to 1000
// [R25] other codes and addresses are parameters
module flash_erase_status_sequencer #(
    parameter logic [19:0] UNLOCK1_ADDR = flash_host_pkg::UNLOCK1_ADDR_DEF,
    parameter logic [19:0] UNLOCK2_ADDR = flash_host_pkg::UNLOCK2_ADDR_DEF,
    parameter logic [7:0]  UNLOCK1_DATA = flash_host_pkg::UNLOCK1_DATA_DEF,
    parameter logic [7:0]  UNLOCK2_DATA = flash_host_pkg::UNLOCK2_DATA_DEF,
    parameter logic [19:0] CMD_ADDR     = flash_host_pkg::CMD_ADDR_DEF,
    parameter logic [7:0]  SUSPEND_CODE = flash_host_pkg::SUSPEND_DEF,
    parameter logic [7:0]  RESUME_CODE  = flash_host_pkg::RESUME_DEF,
    parameter logic [7:0]  RDSTAT_CODE  = flash_host_pkg::RDSTAT_DEF,
    parameter logic [7:0]  CLRSTAT_CODE = flash_host_pkg::CLRSTAT_DEF,
    parameter logic [7:0]  RDARRAY_CODE = flash_host_pkg::RDARRAY_DEF
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // flash pins
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic      [19:0] addr,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe,
    output logic             deep_powerdown_n
);
    import flash_host_pkg::*;

    typedef struct packed {
        phase_type   st;
        op_type      op;
        logic [2:0]  idx;
        logic [7:0]  cnt;
        logic [7:0]  rec;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dq_oe;
        logic [19:0] addr;
        logic [15:0] dq_out;
        logic [15:0] dq_s1;
        logic [15:0] dq_s2;
        logic        pwd_req;
        logic        pwd_n;
        logic [3:0]  sector;
        logic [7:0]  status;
        logic        refused;
        logic        fail_lock;
        logic        erasing;
        logic        suspended;
        logic        wait_mode;
        logic [31:0] rdata;
    } state_type;

    state_type s;
    state_type next_s;
    op_type    req;
    step_type  stp;
    logic      busy;

    // ************************************************************
    // decoding
    // ************************************************************

    // map a register command code onto a flash operation
    function automatic op_type cmd_decode(input logic [3:0] c);
        unique case (c)
            CMD_CHIP:    cmd_decode = op_chip;
            CMD_SECTOR:  cmd_decode = op_sector;
            CMD_SUSPEND: cmd_decode = op_suspend;
            CMD_RESUME:  cmd_decode = op_resume;
            CMD_RDSTAT:  cmd_decode = op_rdstat;
            CMD_CLRSTAT: cmd_decode = op_clrstat;
            CMD_RDARRAY: cmd_decode = op_rdarray;
            CMD_POLL:    cmd_decode = op_poll;
            default:     cmd_decode = op_none;
        endcase
    endfunction

    // one bus cycle of a sequence: address, data, last flag
    function automatic step_type step_of(input op_type o, input logic [2:0] i,
                                         input logic [3:0] sec);
        step_of = '{CMD_ADDR, 8'h00, 1'b1, 1'b0};
        unique case (o)
            op_chip, op_sector: begin
                step_of.last = (i == 3'd5);
                unique case (i)
                    3'd0, 3'd3: step_of = '{UNLOCK1_ADDR, UNLOCK1_DATA, 1'b0, 1'b0};
                    3'd1, 3'd4: step_of = '{UNLOCK2_ADDR, UNLOCK2_DATA, 1'b0, 1'b0};
                    3'd2: step_of = '{UNLOCK1_ADDR, SETUP_CODE, 1'b0, 1'b0};
                    default: begin
                        if (o == op_chip) begin
                            step_of.data = CHIP_CODE; // R1
                        end else begin
                            step_of.addr = {sec, 16'h0000}; // R2 R6
                            step_of.data = SECTOR_CODE; // R2
                        end
                    end
                endcase
            end
            op_suspend: step_of.data = SUSPEND_CODE; // R25
            op_resume:  step_of.data = RESUME_CODE;
            op_rdstat:  step_of.data = RDSTAT_CODE; // R12 R22
            op_clrstat: step_of.data = CLRSTAT_CODE;
            op_rdarray: step_of.data = RDARRAY_CODE; // R12
            default:    step_of.is_read = 1'b1;
        endcase
    endfunction

    // pending command request from the register port
    assign req = (reg_wr && reg_addr == CMD_OFS) ? cmd_decode(reg_wdata[3:0]) : op_none;
    assign busy = (s.st != st_idle) || (s.rec != 8'h00) || s.wait_mode;

    // ************************************************************
    // sequencer
    // ************************************************************

    // whole next state in one place; pins follow the phase
    always_comb begin
        next_s = s;
        next_s.dq_s1 = dq_in;
        next_s.dq_s2 = s.dq_s1;
        next_s.rdata = 32'h0000_0000;
        stp = step_of(s.op, s.idx, s.sector);
        // register reads and plain writes
        if (reg_rd) begin
            unique case (reg_addr)
                STATUS_OFS: begin
                    next_s.rdata[7:0] = s.status;
                    next_s.rdata[BUSY_POS] = busy;
                    next_s.rdata[REFUSED_POS] = s.refused;
                    next_s.rdata[LOCK_POS] = s.fail_lock;
                    next_s.rdata[ERASING_POS] = s.erasing;
                    next_s.rdata[SUSP_POS] = s.suspended;
                end
                SECTOR_OFS: next_s.rdata[3:0] = s.sector;
                CTRL_OFS:   next_s.rdata[PWD_POS] = s.pwd_req;
                default:    next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_wr && reg_addr == SECTOR_OFS) begin
            next_s.sector = reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == CTRL_OFS) begin
            next_s.pwd_req = reg_wdata[PWD_POS];
        end
        unique case (s.st)
            st_idle: begin
                if (s.rec != 8'h00) begin
                    next_s.rec = s.rec - 8'h01;
                end else if (reg_wr && reg_addr == CMD_OFS
                             && reg_wdata[3:0] == CMD_WAIT) begin
                    next_s.wait_mode = 1'b1;
                end else if (s.wait_mode) begin
                    next_s.op = op_poll; // R14
                    next_s.idx = 3'd0;
                    next_s.st = st_setup;
                end else if (req != op_none) begin
                    if (((req == op_chip || req == op_sector)
                         && (s.fail_lock || s.erasing)) // R20
                        || (req == op_suspend && (!s.erasing || s.suspended)) // R7
                        || (req == op_resume && !s.suspended) // R11
                        || (s.suspended && (req == op_chip || req == op_sector
                                            || req == op_clrstat))) begin // R9
                        next_s.refused = 1'b1;
                    end else begin
                        next_s.refused = 1'b0;
                        next_s.op = req;
                        next_s.idx = 3'd0;
                        next_s.st = st_setup;
                    end
                end
            end
            st_setup: begin
                // address already stable; falling strobe latches it
                next_s.we_n = 1'b0; // R3
                next_s.cnt = WE_CYC - 8'h01;
                next_s.st = st_strobe;
            end
            st_strobe: begin
                if (s.cnt == 8'h00) begin
                    next_s.we_n = 1'b1; // R3 R4
                    next_s.st = st_hold;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            st_hold: begin
                // data held one cycle past the rising strobe
                next_s.ce_n = 1'b1;
                next_s.dq_oe = 1'b0;
                next_s.cnt = GAP_CYC - 8'h01;
                next_s.st = st_gap;
            end
            st_read: begin
                if (s.cnt == 8'h00) begin
                    next_s.status = s.dq_s2[7:0] & STATUS_MASK; // R13 R14
                    next_s.ce_n = 1'b1;
                    next_s.oe_n = 1'b1;
                    next_s.cnt = GAP_CYC - 8'h01;
                    next_s.st = st_gap;
                end else begin
                    next_s.cnt = s.cnt - 8'h01;
                end
            end
            st_gap: begin
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else if (!stp.last) begin
                    next_s.idx = s.idx + 3'd1;
                    next_s.st = st_setup;
                end else begin
                    next_s.st = st_idle;
                    unique case (s.op)
                        op_chip, op_sector: next_s.erasing = 1'b1; // R4 R16
                        op_suspend: begin
                            next_s.suspended = 1'b1; // R8
                            next_s.wait_mode = 1'b1;
                        end
                        op_resume:  next_s.suspended = 1'b0; // R11
                        op_clrstat: next_s.fail_lock = 1'b0; // R15 R20
                        op_poll: begin
                            // ready bit decides; fail bits lock out erase
                            if (s.status[READY_POS]) begin // R21 R23
                                next_s.wait_mode = 1'b0;
                                if (!s.status[SUSPEND_POS]) begin
                                    next_s.erasing = 1'b0; // R5
                                end
                                if (s.status[ERASE_FAIL_POS]
                                    || s.status[PROGRAM_FAIL_POS]) begin
                                    next_s.fail_lock = 1'b1; // R15 R20
                                end
                            end
                        end
                        default: next_s.op = s.op;
                    endcase
                end
            end
            default: next_s.st = st_idle;
        endcase
        // drive pins for a freshly entered bus cycle
        stp = step_of(next_s.op, next_s.idx, next_s.sector);
        if (next_s.st == st_setup && s.st != st_setup) begin
            next_s.ce_n = 1'b0;
            next_s.addr = stp.addr;
            if (stp.is_read) begin
                next_s.oe_n = 1'b0; // R14
                next_s.dq_oe = 1'b0;
                next_s.cnt = RD_CYC - 8'h01;
                next_s.st = st_read;
            end else begin
                next_s.dq_out = {8'h00, stp.data};
                next_s.dq_oe = 1'b1;
            end
        end
        // powerdown aborts everything; status returns to 1000
        next_s.pwd_n = !next_s.pwd_req;
        if (next_s.pwd_req) begin // R10 R24
            next_s.st = st_idle;
            next_s.ce_n = 1'b1;
            next_s.oe_n = 1'b1;
            next_s.we_n = 1'b1;
            next_s.dq_oe = 1'b0;
            next_s.erasing = 1'b0;
            next_s.suspended = 1'b0;
            next_s.wait_mode = 1'b0;
            next_s.fail_lock = 1'b0;
            next_s.status = STATUS_RESET; // R17
            next_s.rec = REC_CYC;
        end
    end

    // state register, synchronous reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= st_idle;
            s.op <= op_none;
            s.ce_n <= 1'b1;
            s.oe_n <= 1'b1;
            s.we_n <= 1'b1;
            s.pwd_n <= 1'b1;
            s.status <= STATUS_RESET; // R17
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s.rdata;
    assign ce_n = s.ce_n;
    assign oe_n = s.oe_n;
    assign we_n = s.we_n;
    assign addr = s.addr;
    assign dq_out = s.dq_out;
    assign dq_oe = s.dq_oe;
    assign deep_powerdown_n = s.pwd_n;

endmodule

/* sim/flash_seq_sva.sv */
// assertions on the host controller flash pins
`timescale 1ns/1ps
module flash_seq_sva (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    // flash pins
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic [19:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        deep_powerdown_n
);
    import flash_host_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ************************************************************
    // write and read cycles
    // ************************************************************
    a_we_in_ce: assert property (!we_n |-> !ce_n && oe_n && dq_oe)
        else $error("write strobe outside write cycle");
    a_we_low_len: assert property ($fell(we_n) |-> (!we_n)[*2] ##1 we_n)
        else $error("write strobe low time wrong");
    a_we_hold_data: assert property ($rose(we_n) |-> !ce_n && dq_oe && $stable(dq_out)
        && $stable(addr))
        else $error("bus moved at strobe rise");
    a_rd_len: assert property ($fell(oe_n) |-> (!oe_n && !ce_n && !dq_oe)[*5]
        ##1 (oe_n && ce_n))
        else $error("read strobe length wrong");
    a_rd_no_write: assert property (!oe_n |-> we_n && !dq_oe)
        else $error("bus driven during a read");
    a_upper_zero: assert property (dq_oe |-> dq_out[15:8] == 8'h00)
        else $error("upper data byte not zero");
    // ************************************************************
    // deep power-down
    // ************************************************************
    a_pwd_enter: assert property (reg_wr && reg_addr == CTRL_OFS && reg_wdata[0]
        |-> ##[1:2] !deep_powerdown_n)
        else $error("powerdown pin not low");
    a_pwd_quiet: assert property (!deep_powerdown_n && !$past(deep_powerdown_n)
        |-> ce_n && oe_n && we_n && !dq_oe)
        else $error("pins active during powerdown");
    c_write: cover property ($fell(we_n));
    c_read: cover property ($fell(oe_n));
    c_pwd: cover property ($fell(deep_powerdown_n));
endmodule

/* sim/flash_dev_model.sv */
// behavioural flash device answering erase and status sequences
`timescale 1ns/1ps
module flash_dev_model (
    // pins from the controller
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [19:0] addr,
    input  wire logic [15:0] dq_out,
    input  wire logic        deep_powerdown_n,
    output logic      [15:0] dq_in,
    // test hooks
    input  wire logic        fail_next,
    output logic      [7:0]  erase_count,
    output logic      [19:0] erase_addr,
    output logic      [7:0]  erase_code
);
    import flash_host_pkg::*;
    logic [19:0] lat_addr;
    logic [7:0]  stat;
    logic [7:0]  snap;
    logic [2:0]  step;
    logic        susp;
    int          polls;
    // ************************************************************
    // command interface
    // ************************************************************
    function automatic logic step_ok(input logic [2:0] s, input logic [19:0] a,
                                     input logic [7:0] d);
        case (s)
            3'd0, 3'd3: step_ok = a == UNLOCK1_ADDR_DEF && d == UNLOCK1_DATA_DEF;
            3'd2: step_ok = a == UNLOCK1_ADDR_DEF && d == SETUP_CODE;
            default: step_ok = a == UNLOCK2_ADDR_DEF && d == UNLOCK2_DATA_DEF;
        endcase
    endfunction
    initial begin
        stat = STATUS_RESET;
        snap = STATUS_RESET;
        step = 3'd0;
        susp = 1'b0;
        polls = 0;
        erase_count = 8'h00;
        erase_addr = 20'h00000;
        erase_code = 8'h00;
    end
    // address on the falling, data on the rising write strobe
    always @(negedge we_n) lat_addr = addr;
    always @(posedge we_n or negedge deep_powerdown_n) begin
        if (!deep_powerdown_n) begin
            stat = STATUS_RESET;
            step = 3'd0;
            susp = 1'b0;
        end else if (step == 3'd5) begin
            step = 3'd0;
            // fail bits and suspension both block a new erase
            if ((dq_out[7:0] == CHIP_CODE || dq_out[7:0] == SECTOR_CODE)
                && stat[5:4] == 2'b00 && !susp) begin
                stat = 8'h00;
                polls = 3;
                erase_count = erase_count + 8'h01;
                erase_addr = lat_addr;
                erase_code = dq_out[7:0];
            end
        end else if (step_ok(step, lat_addr, dq_out[7:0])) begin
            step = step + 3'd1;
        end else begin
            step = 3'd0;
            if (dq_out[7:0] == SUSPEND_DEF && !stat[7] && !susp) begin
                stat = 8'h40;
                susp = 1'b1;
            end else if (dq_out[7:0] == RESUME_DEF && susp) begin
                stat = 8'h00;
                susp = 1'b0;
                polls = 3;
            end else if (dq_out[7:0] == CLRSTAT_DEF && !susp) begin
                stat[5:4] = 2'b00;
            end else if (dq_out[7:0] == RDARRAY_DEF) begin
                stat[2] = 1'b0;
            end
        end
    end
    // snapshot at the later falling strobe, then let the erase advance
    always @(negedge oe_n or negedge ce_n) begin
        if (!ce_n && !oe_n) begin
            snap = stat;
            if (susp && stat == 8'h40) begin
                stat = 8'hC0;
            end else if (!stat[7] && !susp && polls > 0) begin
                polls = polls - 1;
                if (polls == 0) stat = fail_next ? 8'hA0 : 8'h80;
            end
        end
    end
    // a released bus shows the inverse, so a stale sample cannot match
    assign dq_in = (!ce_n && !oe_n) ? {8'h00, snap & STATUS_MASK} : ~{8'h00, snap};
endmodule

/* sim/tb_top.sv */
// testbench for the flash erase and status host controller
`timescale 1ns/1ps
module tb_top;
    import flash_host_pkg::*;
    logic        core_clk, rst_n, reg_wr, reg_rd, ce_n, oe_n, we_n, dq_oe;
    logic        deep_powerdown_n, fail_next;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [19:0] addr;
    logic [15:0] dq_in, dq_out;
    logic [7:0]  erase_count;
    logic [19:0] erase_addr;
    logic [7:0]  erase_code;
    logic [31:0] rdat;
    logic [7:0]  cnt0;
    logic [3:0]  secs [3] = '{4'h0, 4'h7, 4'hF};
    int          n_errors, num_checks;
    flash_erase_status_sequencer u_flash_erase_status_sequencer (.*);
    flash_dev_model u_flash_dev_model (.*);
    // ************************************************************
    // register access and checking
    // ************************************************************
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rdat = reg_rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wait_idle();
        int i;
        reg_read(STATUS_OFS);
        for (i = 0; i < 400 && rdat[BUSY_POS] !== 1'b0; i++) reg_read(STATUS_OFS);
        if (i == 400) begin
            n_errors++;
            $display("ERROR %0t: controller stays busy", $time);
            give_verdict();
        end
    endtask
    task automatic run_cmd(input logic [3:0] c);
        reg_write(CMD_OFS, {28'h0, c});
        wait_idle();
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fail_next = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        reg_read(STATUS_OFS);
        chk(rdat, 32'h80, 32'h1FFF);
        reg_read(4'h2);
        chk(rdat, 32'h0, 32'hFFFFFFFF);
        // chip erase, one busy poll, then wait for ready
        cnt0 = erase_count;
        run_cmd(CMD_CHIP);
        chk({24'h0, erase_count}, {24'h0, cnt0 + 8'h01}, 32'hFF);
        chk({24'h0, erase_code}, 32'h10, 32'hFF);
        run_cmd(CMD_POLL);
        chk(rdat, 32'h800, 32'h1EFF);
        run_cmd(CMD_WAIT);
        chk(rdat, 32'h80, 32'h1FFF);
        // lowest, middle and highest sector
        for (int k = 0; k < 3; k++) begin
            reg_write(SECTOR_OFS, {28'h0, secs[k]});
            run_cmd(CMD_SECTOR);
            chk({12'h0, erase_addr}, {12'h0, secs[k], 16'h0}, 32'hFFFFF);
            chk({24'h0, erase_code}, 32'h30, 32'hFF);
            run_cmd(CMD_WAIT);
            chk(rdat, 32'h80, 32'h1FFF);
        end
        // suspend is only taken while an erase runs
        run_cmd(CMD_SUSPEND);
        chk(rdat, 32'h200, 32'h200);
        run_cmd(CMD_CHIP);
        cnt0 = erase_count;
        run_cmd(CMD_SUSPEND);
        chk(rdat, 32'h10C0, 32'h17FF);
        run_cmd(CMD_SECTOR);
        chk(rdat, 32'h200, 32'h200);
        chk({24'h0, erase_count}, {24'h0, cnt0}, 32'hFF);
        run_cmd(CMD_RESUME);
        chk(rdat, 32'h0, 32'h1200);
        run_cmd(CMD_RESUME);
        chk(rdat, 32'h200, 32'h200);
        run_cmd(CMD_RDSTAT);
        chk(rdat, 32'h0, 32'h200);
        run_cmd(CMD_WAIT);
        chk(rdat, 32'h80, 32'h1FFF);
        // a failed erase locks out erases until status is cleared
        fail_next <= 1'b1;
        run_cmd(CMD_CHIP);
        run_cmd(CMD_WAIT);
        chk(rdat, 32'h4A0, 32'h1FFF);
        cnt0 = erase_count;
        run_cmd(CMD_CHIP);
        chk(rdat, 32'h200, 32'h200);
        chk({24'h0, erase_count}, {24'h0, cnt0}, 32'hFF);
        run_cmd(CMD_RDARRAY);
        chk(rdat, 32'h400, 32'h600);
        run_cmd(CMD_CLRSTAT);
        run_cmd(CMD_POLL);
        chk(rdat, 32'h80, 32'h4FF);
        run_cmd(CMD_SECTOR);
        chk({24'h0, erase_count}, {24'h0, cnt0 + 8'h01}, 32'hFF);
        run_cmd(CMD_WAIT);
        chk(rdat, 32'h4A0, 32'h1FFF);
        // powerdown clears the fail state
        fail_next <= 1'b0;
        reg_write(CTRL_OFS, 32'h1);
        repeat (4) @(posedge core_clk);
        chk({31'h0, deep_powerdown_n}, 32'h0, 32'h1);
        reg_write(CTRL_OFS, 32'h0);
        wait_idle();
        chk(rdat, 32'h80, 32'h1FFF);
        run_cmd(CMD_POLL);
        chk(rdat, 32'h80, 32'hFF);
        give_verdict();
    end
endmodule
bind flash_erase_status_sequencer flash_seq_sva u_flash_seq_sva (.*);
